// File: rsr_defines.svh
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// Instruction cycles taken by a subroutine return.
`define RSR_RET_CYCLES 2
// Reset values of the working register, status flags and program counter.
`define RSR_W_RESET 8'h00
`define RSR_PC_RESET 13'h0000
`define RSR_FLAG_RESET 1'b0
// Destination selector values.
`define RSR_DEST_W 1'b0
`define RSR_DEST_F 1'b1
// Nibble boundary used for the digit carry.
`define RSR_NIB_MSB 3
`define RSR_BYTE_MSB 7

`endif

// File: rsr_pkg.sv
package rsr_pkg;
  typedef enum logic [2:0] {
    RSR_OP_NONE,
    RSR_OP_RETURN,
    RSR_OP_ROTATE_LEFT,
    RSR_OP_ROTATE_RIGHT,
    RSR_OP_SUB_REG,
    RSR_OP_SUB_LIT
  } rsr_op_t;
endpackage

// File: rsr_alu.sv
`timescale 1ns/10ps
`include "rsr_defines.svh"

module rsr_alu (
  // Operands.
  input wire rsr_pkg::rsr_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] w,
  input wire logic carry_in,
  // Results.
  output logic [7:0] result,
  output logic carry_out,
  output logic nibble_carry_out,
  output logic zero_out
);
  import rsr_pkg::*;

  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    diff = {1'b0, opa} - {1'b0, w};
    ndiff = {1'b0, opa[`RSR_NIB_MSB:0]} - {1'b0, w[`RSR_NIB_MSB:0]};
    result = opa;
    carry_out = carry_in;
    case (op)
      RSR_OP_ROTATE_LEFT: begin
        result = {opa[`RSR_BYTE_MSB-1:0], carry_in};
        carry_out = opa[`RSR_BYTE_MSB];
      end
      RSR_OP_ROTATE_RIGHT: begin
        result = {carry_in, opa[`RSR_BYTE_MSB:1]};
        carry_out = opa[0];
      end
      RSR_OP_SUB_REG, RSR_OP_SUB_LIT: begin
        result = diff[7:0];
        carry_out = ~diff[8];
      end
      default: begin
        result = opa;
        carry_out = carry_in;
      end
    endcase
    nibble_carry_out = ~ndiff[4];
    zero_out = (result == 8'h00);
  end
endmodule // rsr_alu

// File: rsr_exec.sv
// Contract
// - Return pops stack top into the counter; two cycles, flags kept.
// - Rotate left: carry into bit 0, old bit 7 to carry, one cycle.
// - Rotate right: carry into bit 7, old bit 0 to carry, only carry.
// - Destination 0 writes the working register, 1 the file register; literal subtract always writes the working register.
// - Subtract: file (or literal) minus working; sets carry, nibble carry and zero.
`timescale 1ns/10ps
`include "rsr_defines.svh"

module rsr_exec #(
  parameter int PC_W = 13
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Instruction issue.
  input wire logic issue,
  input wire rsr_pkg::rsr_op_t op,
  input wire logic dest,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] literal,
  input wire logic [PC_W-1:0] stack_top_entry,
  // Handshake.
  output logic busy,
  output logic stack_pop,
  // File register write.
  output logic file_we,
  output logic [7:0] file_wdata,
  // Architectural state.
  output logic [7:0] w_reg,
  output logic [PC_W-1:0] pc,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag
);
  import rsr_pkg::*;

  // Refuse program counter widths that this core does not support.
  if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
    $error("PC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset release.
  // Reset asserts at once but is released only on a clock edge, so no
  // register leaves reset in the middle of a cycle.
  logic rst_s1_q, rst_s1_d, rst_s2_q, rst_s2_d;
  always_comb begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end
  logic rst_ok;
  assign rst_ok = rst_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // Datapath.
  logic [7:0] alu_a, alu_res;
  logic alu_c, alu_dc, alu_z;
  assign alu_a = (op == RSR_OP_SUB_LIT) ? literal : file_rdata;

  rsr_alu u_alu (
    .op(op),
    .opa(alu_a),
    .w(w_reg),
    .carry_in(carry_flag),
    .result(alu_res),
    .carry_out(alu_c),
    .nibble_carry_out(alu_dc),
    .zero_out(alu_z)
  );

  ////////////////////////////////////////////////////////////////////////
  // Execution state.
  typedef enum logic {RSR_ST_IDLE, RSR_ST_RET2} rsr_state_t;
  rsr_state_t state_q, state_d;
  logic [7:0] w_q, w_d, fw_q, fw_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic c_q, c_d, dc_q, dc_d, z_q, z_d, fwe_q, fwe_d;
  logic take, is_rot, is_sub, to_file;

  always_comb begin
    // A request during the second cycle of a return is dropped silently.
    take = issue && (state_q == RSR_ST_IDLE);
    is_rot = (op == RSR_OP_ROTATE_LEFT) || (op == RSR_OP_ROTATE_RIGHT);
    is_sub = (op == RSR_OP_SUB_REG) || (op == RSR_OP_SUB_LIT);
    to_file = (dest == `RSR_DEST_F) && (op != RSR_OP_SUB_LIT);
    state_d = state_q;
    w_d = w_q;
    fw_d = fw_q;
    // The file write strobe lasts one cycle unless a new write follows.
    fwe_d = 1'b0;
    pc_d = pc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    case (state_q)
      RSR_ST_IDLE: begin
        if (take && op == RSR_OP_RETURN) begin
          pc_d = stack_top_entry;
          state_d = RSR_ST_RET2;
        end else if (take && (is_rot || is_sub)) begin
          c_d = alu_c;
          if (is_sub) begin
            dc_d = alu_dc;
            z_d = alu_z;
          end
          if (to_file) begin
            fwe_d = 1'b1;
            fw_d = alu_res;
          end else begin
            w_d = alu_res;
          end
        end
      end
      RSR_ST_RET2: begin
        state_d = RSR_ST_IDLE;
      end
      default: begin
        state_d = RSR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= RSR_ST_IDLE;
      w_q <= `RSR_W_RESET;
      fw_q <= `RSR_W_RESET;
      fwe_q <= 1'b0;
      pc_q <= PC_W'(`RSR_PC_RESET);
      c_q <= `RSR_FLAG_RESET;
      dc_q <= `RSR_FLAG_RESET;
      z_q <= `RSR_FLAG_RESET;
    end else begin
      state_q <= state_d;
      w_q <= w_d;
      fw_q <= fw_d;
      fwe_q <= fwe_d;
      pc_q <= pc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
    end
  end

  assign busy = (state_q == RSR_ST_RET2);
  assign stack_pop = take && (op == RSR_OP_RETURN);
  assign file_we = fwe_q;
  assign file_wdata = fw_q;
  assign w_reg = w_q;
  assign pc = pc_q;
  assign carry_flag = c_q;
  assign nibble_carry_flag = dc_q;
  assign zero_flag = z_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_ret_two_cycles: assert property (
    @(posedge clk) disable iff (!rst_ok)
    stack_pop |=> busy ##1 !busy)
    else $error("return not two cycles");
  chk_ret_loads_pc: assert property (
    @(posedge clk) disable iff (!rst_ok)
    stack_pop |=> pc == $past(stack_top_entry))
    else $error("pc not loaded");
  chk_ret_flags_kept: assert property (
    @(posedge clk) disable iff (!rst_ok)
    stack_pop |=> $stable(carry_flag) && $stable(zero_flag)
      && $stable(nibble_carry_flag))
    else $error("return altered flags");
  chk_busy_refused: assert property (
    @(posedge clk) disable iff (!rst_ok)
    busy |=> $stable(w_reg) && $stable(pc) && !file_we)
    else $error("request taken while busy");
  chk_rol_result: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_ROTATE_LEFT && dest == `RSR_DEST_W |=>
      w_reg == {$past(file_rdata[6:0]), $past(carry_flag)}
      && carry_flag == $past(file_rdata[7]))
    else $error("rotate left bad");
  chk_ror_result: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_ROTATE_RIGHT && dest == `RSR_DEST_W |=>
      w_reg == {$past(carry_flag), $past(file_rdata[7:1])}
      && carry_flag == $past(file_rdata[0])
      && $stable(zero_flag))
    else $error("rotate right bad");
  chk_dest_file: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && is_rot && dest == `RSR_DEST_F |=> file_we && $stable(w_reg))
    else $error("file destination bad");
  chk_rol_file_data: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_ROTATE_LEFT && dest == `RSR_DEST_F |=>
      file_wdata == {$past(file_rdata[6:0]), $past(carry_flag)})
    else $error("rotate left file data bad");
  chk_sub_value: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_SUB_REG && dest == `RSR_DEST_W |=>
      w_reg == 8'($past(file_rdata) - $past(w_reg)))
    else $error("subtract value bad");
  chk_sub_flags: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_SUB_REG |=>
      carry_flag == ($past(w_reg) <= $past(file_rdata))
      && zero_flag == ($past(w_reg) == $past(file_rdata))
      && nibble_carry_flag == ($past(w_reg[3:0]) <= $past(file_rdata[3:0])))
    else $error("subtract flags bad");
  chk_sub_lit_value: assert property (
    @(posedge clk) disable iff (!rst_ok)
    take && op == RSR_OP_SUB_LIT |=>
      w_reg == 8'($past(literal) - $past(w_reg))
      && carry_flag == ($past(w_reg) <= $past(literal))
      && !file_we)
    else $error("literal subtract bad");
endmodule // rsr_exec

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import rsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  rsr_op_t op = RSR_OP_NONE;
  logic dest = 1'b0;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] literal = 8'h00;
  logic [12:0] stack_top_entry = 13'h0000;
  logic busy, stack_pop, file_we, carry_flag, nibble_carry_flag, zero_flag;
  logic [7:0] file_wdata, w_reg;
  logic [12:0] pc;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 5;
  logic [7:0] ew = 8'h00;
  logic [7:0] ewd = 8'h00;
  logic [12:0] epc = 13'h0000;
  logic ec = 1'b0, edc = 1'b0, ez = 1'b0, ewe = 1'b0, eb = 1'b0;
  rsr_op_t ro;
  logic rd, ri;
  logic [7:0] rf, rk;

  always #10 clk = ~clk;

  rsr_exec #(.PC_W(13)) dut (.clk(clk), .rst_n(rst_n), .issue(issue),
    .op(op), .dest(dest), .file_rdata(file_rdata), .literal(literal),
    .stack_top_entry(stack_top_entry), .busy(busy), .stack_pop(stack_pop),
    .file_we(file_we), .file_wdata(file_wdata), .w_reg(w_reg), .pc(pc),
    .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
    .zero_flag(zero_flag));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected rotate through carry: new carry in bit 8, result below.
  function automatic logic [8:0] exp_rot(input logic left,
    input logic [7:0] f, input logic c);
    if (left) return {f[7], f[6:0], c};
    return {f[0], c, f[7:1]};
  endfunction

  // Expected difference with the borrow in bit 8.
  function automatic logic [8:0] exp_sub(input logic [7:0] a,
    input logic [7:0] b);
    return {1'b0, a} - {1'b0, b};
  endfunction

  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Issues one operation and checks the results of the one before it.
  task step(input rsr_op_t o, input logic d, input logic [7:0] f,
            input logic [7:0] k, input logic iss);
    logic [8:0] s;
    logic [7:0] r, v;
    logic [12:0] t;
    logic tk;
    t = 13'($random(seed));
    @(posedge clk);
    issue <= iss;
    op <= o;
    dest <= d;
    file_rdata <= f;
    literal <= k;
    stack_top_entry <= t;
    #1;
    tk = iss && !eb;
    chk("stack_pop", 16'(tk && o == RSR_OP_RETURN), 16'(stack_pop));
    chk("busy", 16'(eb), 16'(busy));
    chk("w_reg", 16'(ew), 16'(w_reg));
    chk("pc", 16'(epc), 16'(pc));
    chk("carry", 16'(ec), 16'(carry_flag));
    chk("nibble", 16'(edc), 16'(nibble_carry_flag));
    chk("zero", 16'(ez), 16'(zero_flag));
    chk("file_we", 16'(ewe), 16'(file_we));
    if (ewe) chk("file_wdata", 16'(ewd), 16'(file_wdata));
    ewe = 1'b0;
    eb = 1'b0;
    if (tk) begin
      v = (o == RSR_OP_SUB_LIT) ? k : f;
      s = exp_sub(v, ew);
      r = s[7:0];
      case (o)
        RSR_OP_RETURN: begin
          epc = t;
          eb = 1'b1;
        end
        RSR_OP_ROTATE_LEFT: begin
          {ec, r} = exp_rot(1'b1, f, ec);
        end
        RSR_OP_ROTATE_RIGHT: begin
          {ec, r} = exp_rot(1'b0, f, ec);
        end
        RSR_OP_SUB_REG, RSR_OP_SUB_LIT: begin
          ec = !s[8];
          edc = v[3:0] >= ew[3:0];
          ez = r == 8'h00;
        end
        default: ;
      endcase
      if (o == RSR_OP_SUB_LIT) ew = r;
      else if (o != RSR_OP_NONE && o != RSR_OP_RETURN) begin
        if (d) begin
          ewe = 1'b1;
          ewd = r;
        end else ew = r;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    step(RSR_OP_SUB_REG, 1'b0, 8'h00, 8'h00, 1'b1);
    step(RSR_OP_ROTATE_LEFT, 1'b0, 8'hE6, 8'h00, 1'b1);
    step(RSR_OP_SUB_REG, 1'b1, 8'h0C, 8'h00, 1'b1);
    step(RSR_OP_ROTATE_RIGHT, 1'b1, 8'h01, 8'h00, 1'b1);
    step(RSR_OP_RETURN, 1'b0, 8'h00, 8'h00, 1'b1);
    step(RSR_OP_RETURN, 1'b0, 8'h00, 8'h00, 1'b1);
    step(RSR_OP_SUB_LIT, 1'b1, 8'h00, 8'hCD, 1'b1);
    step(RSR_OP_NONE, 1'b1, 8'hFF, 8'h00, 1'b1);
    repeat (400) begin
      ro = rsr_op_t'(3'($unsigned($random(seed)) % 6));
      rd = 1'($random(seed));
      rf = 8'($random(seed));
      rk = 8'($random(seed));
      ri = 1'($random(seed));
      step(ro, rd, rf, rk, ri);
    end
    step(RSR_OP_NONE, 1'b0, 8'h00, 8'h00, 1'b0);
    results;
  end

  initial begin
    #100000;
    mismatches++;
    results;
  end
endmodule // tb
